/* core/smhp_core.sv */
// Purpose: host management port with SPI, I2C and MDIO slave modes
// Assumes: register port answers a read in the cycle the strobe is high
// Notes: SPI and MDIO run on the serial clock; I2C is oversampled on i_clk
`timescale 1ns/1ps
`default_nettype none
module smhp_core (
	// system clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [1:0] i_mode_strap,
	// serial clock shared by SPI and MDIO
	input wire logic i_lclk,
	// spi pins
	input wire logic i_chip_select_low_n,
	input wire logic i_serial_in_line,
	output logic o_serial_out_line,
	output logic o_serial_out_line_oe,
	// mdio pins, open drain
	input wire logic i_mdio_i,
	output logic o_mdio_o,
	output logic o_mdio_oe,
	// i2c pins, open drain data
	input wire logic i_i2c_scl,
	input wire logic i_i2c_sda_i,
	output logic o_i2c_sda_o,
	output logic o_i2c_sda_oe,
	// device register port
	output logic [smhp_pkg::ADDR_W-1:0] o_reg_addr,
	output logic [smhp_pkg::BYTE_W-1:0] o_reg_wdata,
	output logic o_reg_wr,
	output logic o_reg_rd,
	input wire logic [smhp_pkg::BYTE_W-1:0] i_reg_rdata
);
	import smhp_pkg::*;

	// ---------------- system domain: mode strap ----------------
	logic [1:0] strap_q;
	logic [1:0] settle_reg, settle_next;
	logic [1:0] mode_reg, mode_next;
	logic mode_ok_reg, mode_ok_next;
	logic sys_i2c;
	logic sys_link;

	smhp_sync #(.W(2)) u_strap_sync (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(i_mode_strap), .o_q(strap_q));

	// strap is taken once, after the synchroniser has filled
	always_comb begin
		settle_next = settle_reg;
		mode_next = mode_reg;
		mode_ok_next = mode_ok_reg;
		if (!mode_ok_reg) begin
			if (settle_reg == STRAP_SETTLE) begin
				mode_ok_next = 1'b1;
				mode_next = (strap_q == MODE_I2C || strap_q == MODE_MDIO) ? strap_q : MODE_SPI;
			end else begin
				settle_next = settle_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_reg <= 2'h0;
			mode_reg <= MODE_SPI;
			mode_ok_reg <= 1'b0;
		end else begin
			settle_reg <= settle_next;
			mode_reg <= mode_next;
			mode_ok_reg <= mode_ok_next;
		end
	end

	assign sys_i2c = mode_ok_reg && mode_reg == MODE_I2C;
	assign sys_link = mode_ok_reg && mode_reg != MODE_I2C;

	// ---------------- link domain: SPI and MDIO frames ----------------
	logic [2:0] lmode_q;
	logic l_mdio;
	logic lrst_n;
	logic ack_q;
	logic ack_ok;
	logic bit_in;
	smhp_lk_st_t lst_reg, lst_next, est;
	logic [5:0] cnt_reg, cnt_next;
	logic [31:0] sh_reg, sh_next, din_sh;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic rd_reg, rd_next;
	logic [BYTE_W-1:0] tx_reg, tx_next;
	logic iss, iss_we, iss_wide;
	logic [ADDR_W-1:0] iss_addr;
	logic [WORD_W-1:0] iss_wdata;
	logic req_tgl_reg, req_we_reg, req_wide_reg;
	logic [ADDR_W-1:0] req_addr_reg;
	logic [WORD_W-1:0] req_wdata_reg;
	logic [WORD_W-1:0] hold_reg;
	logic ack_tgl_reg;
	logic sdo_reg, sdo_oe_reg, mdo_oe_reg;
	logic sdo_next, sdo_oe_next, mdo_oe_next;

	smhp_sync #(.W(3)) u_lmode_sync (.i_clk(i_lclk), .i_rst_n(i_rst_n), .i_d({mode_ok_reg, mode_reg}),
		.o_q(lmode_q));
	smhp_sync #(.W(1)) u_ack_sync (.i_clk(i_lclk), .i_rst_n(i_rst_n), .i_d(ack_tgl_reg), .o_q(ack_q));

	assign l_mdio = lmode_q[2] && lmode_q[1:0] == MODE_MDIO;
	// select high ends an SPI frame at once, even with the clock stopped
	assign lrst_n = i_rst_n && (!i_chip_select_low_n || l_mdio);
	assign ack_ok = ack_q == req_tgl_reg;
	assign bit_in = l_mdio ? i_mdio_i : i_serial_in_line;
	assign din_sh = {sh_reg[30:0], bit_in};

	// frame parser; a freshly reset frame starts in the mode's first phase
	always_comb begin
		lst_next = lst_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		addr_next = addr_reg;
		rd_next = rd_reg;
		tx_next = tx_reg;
		iss = 1'b0;
		iss_we = 1'b0;
		iss_wide = 1'b0;
		iss_addr = addr_reg;
		iss_wdata = '0;
		est = (lst_reg == LK_IDLE) ? (l_mdio ? LK_MPRE : LK_SHDR) : lst_reg;
		unique case (est)
			LK_SHDR: begin
				sh_next = din_sh;
				cnt_next = cnt_reg + 6'h01;
				lst_next = LK_SHDR;
				if (cnt_reg == SPI_HDR_BITS - 6'h01) begin
					cnt_next = 6'h00;
					addr_next = din_sh[ADDR_W-1:0];
					rd_next = din_sh[26:24] == SPI_CMD_RD;
					if (din_sh[26:24] == SPI_CMD_RD || din_sh[26:24] == SPI_CMD_WR) begin
						lst_next = LK_STA;
						iss = din_sh[26:24] == SPI_CMD_RD;
						iss_addr = din_sh[ADDR_W-1:0];
					end else begin
						lst_next = LK_SDROP;
					end
				end
			end
			LK_STA: begin
				// turnaround bit values are never looked at
				cnt_next = cnt_reg + 6'h01;
				if (cnt_reg == SPI_TA_BITS - 6'h01) begin
					lst_next = LK_SDATA;
					cnt_next = 6'h00;
					if (rd_reg) begin
						tx_next = ack_ok ? hold_reg[BYTE_W-1:0] : '0;
						iss = 1'b1;
						iss_addr = addr_reg + 16'h0001;
						addr_next = addr_reg + 16'h0001;
					end
				end
			end
			LK_SDATA: begin
				sh_next = din_sh;
				cnt_next = cnt_reg + 6'h01;
				tx_next = {tx_reg[6:0], 1'b0};
				if (cnt_reg == SPI_BYTE_BITS - 6'h01) begin
					cnt_next = 6'h00;
					iss = 1'b1;
					iss_we = !rd_reg;
					iss_wdata = {8'h00, din_sh[7:0]};
					if (rd_reg) begin
						// next byte was prefetched during the byte just sent
						tx_next = ack_ok ? hold_reg[BYTE_W-1:0] : '0;
						iss_addr = addr_reg + 16'h0001;
					end
					addr_next = addr_reg + 16'h0001;
				end
			end
			LK_SDROP: begin
				lst_next = LK_SDROP;
			end
			LK_MPRE: begin
				lst_next = LK_MPRE;
				if (bit_in) begin
					cnt_next = (cnt_reg == MDIO_PRE_ONES) ? cnt_reg : cnt_reg + 6'h01;
				end else begin
					cnt_next = 6'h00;
					if (cnt_reg == MDIO_PRE_ONES) begin
						lst_next = LK_MST;
					end
				end
			end
			LK_MST: begin
				cnt_next = 6'h00;
				lst_next = bit_in ? LK_MHDR : LK_MPRE;
			end
			LK_MHDR: begin
				sh_next = din_sh;
				cnt_next = cnt_reg + 6'h01;
				if (cnt_reg == MDIO_HDR_BITS - 6'h01) begin
					cnt_next = 6'h00;
					lst_next = LK_MPRE;
					// only PHY ports 1..5 answer; anything else stays silent
					if (din_sh[9:5] >= PHY_FIRST && din_sh[9:5] <= PHY_LAST &&
						(din_sh[11:10] == MDIO_OP_RD || din_sh[11:10] == MDIO_OP_WR)) begin
						lst_next = LK_MTA;
						rd_next = din_sh[11:10] == MDIO_OP_RD;
						addr_next = {din_sh[8:5], PHY_PAGE, 2'h0, din_sh[4:0], 1'b0};
						iss = din_sh[11:10] == MDIO_OP_RD;
						iss_wide = 1'b1;
						iss_addr = {din_sh[8:5], PHY_PAGE, 2'h0, din_sh[4:0], 1'b0};
					end
				end
			end
			LK_MTA: begin
				cnt_next = cnt_reg + 6'h01;
				if (cnt_reg == MDIO_TA_BITS - 6'h01) begin
					cnt_next = 6'h00;
					lst_next = LK_MDATA;
				end
			end
			LK_MDATA: begin
				sh_next = din_sh;
				cnt_next = cnt_reg + 6'h01;
				if (cnt_reg == MDIO_DATA_BITS - 6'h01) begin
					cnt_next = 6'h00;
					lst_next = LK_MPRE;
					iss = !rd_reg;
					iss_we = 1'b1;
					iss_wide = 1'b1;
					iss_wdata = din_sh[WORD_W-1:0];
				end
			end
			default: begin
				lst_next = LK_IDLE;
				cnt_next = 6'h00;
			end
		endcase
	end

	always_ff @(posedge i_lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			lst_reg <= LK_IDLE;
			cnt_reg <= 6'h00;
			sh_reg <= '0;
			addr_reg <= '0;
			rd_reg <= 1'b0;
			tx_reg <= '0;
		end else begin
			lst_reg <= lst_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			addr_reg <= addr_next;
			rd_reg <= rd_next;
			tx_reg <= tx_next;
		end
	end

	// request toggle outlives select so the handshake never slips a phase
	always_ff @(posedge i_lclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			req_tgl_reg <= 1'b0;
			req_we_reg <= 1'b0;
			req_wide_reg <= 1'b0;
			req_addr_reg <= '0;
			req_wdata_reg <= '0;
		end else if (iss) begin
			req_tgl_reg <= !req_tgl_reg;
			req_we_reg <= iss_we;
			req_wide_reg <= iss_wide;
			req_addr_reg <= iss_addr;
			req_wdata_reg <= iss_wdata;
		end
	end

	// output drive values for the falling edge
	always_comb begin
		sdo_next = tx_reg[BYTE_W-1];
		sdo_oe_next = !l_mdio && lst_reg == LK_SDATA && rd_reg;
		mdo_oe_next = 1'b0;
		if (l_mdio && rd_reg) begin
			if (lst_reg == LK_MTA) begin
				mdo_oe_next = cnt_reg == 6'h01;
			end else if (lst_reg == LK_MDATA) begin
				// hold is stable once the returned toggle matches
				mdo_oe_next = ack_ok && !hold_reg[4'hF - cnt_reg[3:0]];
			end
		end
	end

	always_ff @(negedge i_lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			sdo_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
			mdo_oe_reg <= 1'b0;
		end else begin
			sdo_reg <= sdo_next;
			sdo_oe_reg <= sdo_oe_next;
			mdo_oe_reg <= mdo_oe_next;
		end
	end

	assign o_serial_out_line = sdo_reg;
	assign o_serial_out_line_oe = sdo_oe_reg;
	assign o_mdio_o = 1'b0;
	assign o_mdio_oe = mdo_oe_reg;

	// ---------------- system domain: link request sequencer ----------------
	logic req_q;
	logic seen_reg, seen_next;
	smhp_sy_st_t sst_reg, sst_next;
	logic ack_tgl_next;
	logic c_iss, c_we;
	logic [ADDR_W-1:0] c_addr;
	logic [BYTE_W-1:0] c_wdata;
	logic [1:0] c_lane, lane_reg;

	smhp_sync #(.W(1)) u_req_sync (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d(req_tgl_reg), .o_q(req_q));

	// payload is held by the link side until well after the answer
	always_comb begin
		sst_next = sst_reg;
		seen_next = seen_reg;
		ack_tgl_next = ack_tgl_reg;
		c_iss = 1'b0;
		c_we = req_we_reg;
		c_addr = req_addr_reg;
		c_wdata = req_wide_reg ? req_wdata_reg[15:8] : req_wdata_reg[7:0];
		c_lane = 2'h0;
		unique case (sst_reg)
			SY_IDLE: begin
				if (req_q != seen_reg) begin
					seen_next = req_q;
					if (sys_link) begin
						sst_next = SY_OP0;
					end
				end
			end
			SY_OP0: begin
				c_iss = 1'b1;
				c_lane = req_we_reg ? 2'h0 : (req_wide_reg ? 2'h2 : 2'h1);
				sst_next = req_wide_reg ? SY_OP1 : SY_FIN;
			end
			SY_OP1: begin
				// low byte of a 16-bit PHY register sits one byte up
				c_iss = 1'b1;
				c_addr = {req_addr_reg[15:1], 1'b1};
				c_wdata = req_wdata_reg[7:0];
				c_lane = req_we_reg ? 2'h0 : 2'h1;
				sst_next = SY_FIN;
			end
			SY_FIN: begin
				ack_tgl_next = !ack_tgl_reg;
				sst_next = SY_IDLE;
			end
		endcase
	end

	// ---------------- system domain: I2C slave ----------------
	logic [1:0] i2c_q;
	logic [1:0] iprev_reg;
	logic scl_rise, scl_fall, i2c_start, i2c_stop;
	smhp_ic_st_t ist_reg, ist_next;
	logic [3:0] icnt_reg, icnt_next;
	logic [BYTE_W-1:0] ish_reg, ish_next, ibyte;
	logic [ADDR_W-1:0] iaddr_reg, iaddr_next;
	logic iack_reg, iack_next;
	logic [BYTE_W-1:0] itx_reg, itx_next;
	logic ioe_reg, ioe_next;
	logic i_iss, i_we;

	smhp_sync #(.W(2)) u_i2c_sync (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_d({i_i2c_scl, i_i2c_sda_i}),
		.o_q(i2c_q));

	assign scl_rise = i2c_q[1] && !iprev_reg[1];
	assign scl_fall = !i2c_q[1] && iprev_reg[1];
	assign i2c_start = i2c_q[1] && iprev_reg[1] && iprev_reg[0] && !i2c_q[0];
	assign i2c_stop = i2c_q[1] && iprev_reg[1] && !iprev_reg[0] && i2c_q[0];
	assign ibyte = {ish_reg[6:0], i2c_q[0]};

	// byte engine: bits 0..7 then an acknowledge slot
	always_comb begin
		ist_next = ist_reg;
		icnt_next = icnt_reg;
		ish_next = ish_reg;
		iaddr_next = iaddr_reg;
		iack_next = iack_reg;
		ioe_next = ioe_reg;
		itx_next = (o_reg_rd && sys_i2c) ? i_reg_rdata : itx_reg;
		i_iss = 1'b0;
		i_we = 1'b0;
		if (!sys_i2c || i2c_stop) begin
			ist_next = IC_IDLE;
			ioe_next = 1'b0;
		end else if (i2c_start) begin
			ist_next = IC_ADDR;
			icnt_next = 4'h0;
			iack_next = 1'b0;
			ioe_next = 1'b0;
		end else if (scl_rise && ist_reg != IC_IDLE) begin
			if (icnt_reg == I2C_ACK_SLOT) begin
				icnt_next = 4'h0;
				// master answered our data byte: low continues the burst
				if (ist_reg == IC_RD && !iack_reg) begin
					if (i2c_q[0]) begin
						ist_next = IC_IDLE;
					end else begin
						i_iss = 1'b1;
						iaddr_next = iaddr_reg + 16'h0001;
					end
				end
			end else begin
				ish_next = ibyte;
				icnt_next = icnt_reg + 4'h1;
				if (icnt_reg == I2C_ACK_SLOT - 4'h1) begin
					iack_next = 1'b1;
					unique case (ist_reg)
						IC_ADDR: begin
							if (ibyte[7:1] == I2C_DEV_ADDR) begin
								ist_next = ibyte[0] ? IC_RD : IC_RAH;
								i_iss = ibyte[0];
								iaddr_next = ibyte[0] ? iaddr_reg + 16'h0001 : iaddr_reg;
							end else begin
								iack_next = 1'b0;
								ist_next = IC_IDLE;
							end
						end
						IC_RAH: begin
							iaddr_next = {ibyte, iaddr_reg[7:0]};
							ist_next = IC_RAL;
						end
						IC_RAL: begin
							iaddr_next = {iaddr_reg[15:8], ibyte};
							ist_next = IC_WR;
						end
						IC_WR: begin
							i_iss = 1'b1;
							i_we = 1'b1;
							iaddr_next = iaddr_reg + 16'h0001;
						end
						IC_RD: begin
							iack_next = 1'b0;
						end
						default: begin
							ist_next = IC_IDLE;
						end
					endcase
				end
			end
		end else if (scl_fall) begin
			// data changes only while the clock is low
			if (icnt_reg == I2C_ACK_SLOT) begin
				ioe_next = iack_reg;
			end else begin
				ioe_next = ist_reg == IC_RD && !itx_reg[3'h7 - icnt_reg[2:0]];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			iprev_reg <= 2'h3;
			ist_reg <= IC_IDLE;
			icnt_reg <= 4'h0;
			ish_reg <= '0;
			iaddr_reg <= '0;
			iack_reg <= 1'b0;
			itx_reg <= '0;
			ioe_reg <= 1'b0;
		end else begin
			iprev_reg <= i2c_q;
			ist_reg <= ist_next;
			icnt_reg <= icnt_next;
			ish_reg <= ish_next;
			iaddr_reg <= iaddr_next;
			iack_reg <= iack_next;
			itx_reg <= itx_next;
			ioe_reg <= ioe_next;
		end
	end

	assign o_i2c_sda_o = 1'b0;
	assign o_i2c_sda_oe = ioe_reg;

	// ---------------- register port and read capture ----------------
	logic [ADDR_W-1:0] paddr_next;
	logic [BYTE_W-1:0] pwdata_next;
	logic pwr_next, prd_next;
	logic [WORD_W-1:0] hold_next;

	// only the strapped mode may reach the port
	always_comb begin
		paddr_next = sys_i2c ? iaddr_reg : c_addr;
		pwdata_next = sys_i2c ? ish_next : c_wdata;
		pwr_next = sys_i2c ? (i_iss && i_we) : (c_iss && c_we);
		prd_next = sys_i2c ? (i_iss && !i_we) : (c_iss && !c_we);
		hold_next = hold_reg;
		if (o_reg_rd && lane_reg[1]) begin
			hold_next[15:8] = i_reg_rdata;
		end
		if (o_reg_rd && lane_reg[0]) begin
			hold_next[7:0] = i_reg_rdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sst_reg <= SY_IDLE;
			seen_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
			lane_reg <= 2'h0;
			hold_reg <= '0;
			o_reg_addr <= '0;
			o_reg_wdata <= '0;
			o_reg_wr <= 1'b0;
			o_reg_rd <= 1'b0;
		end else begin
			sst_reg <= sst_next;
			seen_reg <= seen_next;
			ack_tgl_reg <= ack_tgl_next;
			lane_reg <= c_lane;
			hold_reg <= hold_next;
			o_reg_addr <= paddr_next;
			o_reg_wdata <= pwdata_next;
			o_reg_wr <= pwr_next;
			o_reg_rd <= prd_next;
		end
	end
endmodule
`default_nettype wire

/* core/smhp_pkg.sv */
// Purpose: constants and types for the switch management host port
// Assumes: one serial clock pin serves SPI and MDIO; I2C is oversampled
// Notes: register contents live outside; this block only reaches them
`default_nettype none
package smhp_pkg;
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	// mode strap codes; the unused code falls back to SPI
	localparam logic [1:0] MODE_SPI = 2'h0;
	localparam logic [1:0] MODE_I2C = 2'h1;
	localparam logic [1:0] MODE_MDIO = 2'h2;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	// spi framing
	localparam logic [5:0] SPI_HDR_BITS = 6'h1B;
	localparam logic [5:0] SPI_TA_BITS = 6'h05;
	localparam logic [5:0] SPI_BYTE_BITS = 6'h08;
	localparam logic [2:0] SPI_CMD_RD = 3'h3;
	localparam logic [2:0] SPI_CMD_WR = 3'h2;
	// i2c framing
	localparam logic [6:0] I2C_DEV_ADDR = 7'h5F;
	localparam logic [3:0] I2C_ACK_SLOT = 4'h8;
	// mdio framing
	localparam logic [5:0] MDIO_PRE_ONES = 6'h20;
	localparam logic [5:0] MDIO_HDR_BITS = 6'h0C;
	localparam logic [5:0] MDIO_TA_BITS = 6'h02;
	localparam logic [5:0] MDIO_DATA_BITS = 6'h10;
	localparam logic [1:0] MDIO_OP_RD = 2'h2;
	localparam logic [1:0] MDIO_OP_WR = 2'h1;
	localparam logic [4:0] PHY_FIRST = 5'h01;
	localparam logic [4:0] PHY_LAST = 5'h05;
	localparam logic [3:0] PHY_PAGE = 4'h1;
	// link side frame states
	typedef enum logic [3:0] {
		LK_IDLE = 4'h0, LK_SHDR = 4'h1, LK_STA = 4'h2, LK_SDATA = 4'h3, LK_SDROP = 4'h4,
		LK_MPRE = 4'h5, LK_MST = 4'h6, LK_MHDR = 4'h7, LK_MTA = 4'h8, LK_MDATA = 4'h9
	} smhp_lk_st_t;
	// system side access sequencer
	typedef enum logic [1:0] {SY_IDLE = 2'h0, SY_OP0 = 2'h1, SY_OP1 = 2'h2, SY_FIN = 2'h3} smhp_sy_st_t;
	// i2c byte roles
	typedef enum logic [2:0] {
		IC_IDLE = 3'h0, IC_ADDR = 3'h1, IC_RAH = 3'h2, IC_RAL = 3'h3, IC_WR = 3'h4, IC_RD = 3'h5
	} smhp_ic_st_t;
endpackage
`default_nettype wire

/* core/smhp_sync.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is a slow level or a toggle
// Notes: only the second stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module smhp_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_reg;

	// first stage feeds the second stage only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_reg <= '0;
			o_q <= '0;
		end else begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* dv/smhp_core_asserts.sv */
// Purpose: port assertions for smhp_core
// Assumes: strap steady while out of reset
// Notes: frame edge count rebuilt from the pins
`timescale 1ns/1ps
`default_nettype none
module smhp_core_chk (
	// clocks, reset, strap
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [1:0] i_mode_strap,
	input wire logic i_lclk,
	// serial pins
	input wire logic i_chip_select_low_n,
	input wire logic i_serial_in_line,
	input wire logic o_serial_out_line_oe,
	input wire logic o_mdio_o,
	input wire logic o_mdio_oe,
	input wire logic o_i2c_sda_oe,
	// register port
	input wire logic [smhp_pkg::ADDR_W-1:0] o_reg_addr,
	input wire logic o_reg_wr,
	input wire logic o_reg_rd
);
	import smhp_pkg::*;
	logic [7:0] cnt_reg, cnt_next;
	logic [2:0] cmd_reg, cmd_next;
	logic md_m, sp_m, stb;
	assign md_m = i_mode_strap == MODE_MDIO;
	assign sp_m = i_mode_strap == MODE_SPI;
	assign stb = o_reg_wr | o_reg_rd;
	// count saturates so long bursts never wrap
	always_comb begin
		cnt_next = cnt_reg + {7'h00, cnt_reg != 8'hFF};
		cmd_next = cnt_reg < 8'h03 ? {cmd_reg[1:0], i_serial_in_line} : cmd_reg;
	end
	// select high clears the frame at once
	always_ff @(posedge i_lclk or posedge i_chip_select_low_n) begin
		if (i_chip_select_low_n) begin
			cnt_reg <= 8'h00;
			cmd_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_next;
			cmd_reg <= cmd_next;
		end
	end
	AST_MDIO_LOW:
		assert property (@(posedge i_clk) disable iff (!i_rst_n) o_mdio_o == 1'b0) else $error("mdio high");
	AST_SO_IDLE:
		assert property (@(posedge i_clk) disable iff (!i_rst_n) i_chip_select_low_n |-> !o_serial_out_line_oe)
		else $error("out driven unselected");
	AST_OE_START:
		assert property (@(posedge i_lclk) disable iff (!i_rst_n) $rose(o_serial_out_line_oe) |-> cnt_reg == 8'h20)
		else $error("drive start edge");
	AST_OE_READ:
		assert property (@(posedge i_lclk) disable iff (!i_rst_n)
			o_serial_out_line_oe |-> cnt_reg >= 8'h20 && cmd_reg == SPI_CMD_RD) else $error("drive outside read");
	AST_PHY_ONLY:
		assert property (@(posedge i_clk) disable iff (!i_rst_n) md_m && stb |->
			o_reg_addr[15:12] inside {[4'h1:4'h5]} && o_reg_addr[11:6] == {PHY_PAGE, 2'h0}) else $error("non phy");
	AST_WORD_PAIR:
		assert property (@(posedge i_clk) disable iff (!i_rst_n) md_m && stb && !o_reg_addr[0] |=> o_reg_wr ==
			$past(o_reg_wr) && o_reg_addr == $past(o_reg_addr) + 16'h0001) else $error("word split");
	AST_MODE_ONLY:
		assert property (@(posedge i_clk) disable iff (!i_rst_n) sp_m |-> !o_mdio_oe && !o_i2c_sda_oe)
		else $error("other mode active");
	AST_WR_ONE:
		assert property (@(posedge i_clk) disable iff (!i_rst_n) sp_m && o_reg_wr |=> !o_reg_wr) else $error("long wr");
	// main scenarios reached
	cover property (@(posedge i_lclk) $rose(o_serial_out_line_oe));
	cover property (@(posedge i_clk) md_m && o_reg_wr);
	cover property (@(posedge i_clk) md_m && o_reg_rd);
	cover property (@(posedge i_clk) o_i2c_sda_oe && o_reg_wr);
endmodule
bind smhp_core smhp_core_chk chk_u (.i_clk, .i_rst_n, .i_mode_strap, .i_lclk, .i_chip_select_low_n,
	.i_serial_in_line, .o_serial_out_line_oe, .o_mdio_o, .o_mdio_oe, .o_i2c_sda_oe, .o_reg_addr, .o_reg_wr, .o_reg_rd);
`default_nettype wire

/* dv/smhp_host_model.sv */
// Purpose: host side of the link, SPI master, MDIO controller and I2C master
// Assumes: SPI clock stands low between frames
// Notes: released SPI out reads as z; MDIO and SDA are pulled up in the bench
`timescale 1ns/1ps
`default_nettype none
module smhp_host_model (
	// host driven pins
	output logic o_lclk,
	output logic o_cs_n,
	output logic o_sin,
	output logic o_md_o,
	output logic o_md_oe,
	output logic o_scl,
	output logic o_sda,
	// device driven pins
	input wire logic i_so,
	input wire logic i_so_oe,
	input wire logic i_md,
	input wire logic i_sda
);
	import smhp_pkg::*;
	// idle: clock low, select high
	initial begin
		o_lclk = 1'b0;
		o_cs_n = 1'b1;
		o_sin = 1'b0;
		o_md_o = 1'b1;
		o_md_oe = 1'b0;
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// spi frame at 48 ns; undriven out reads as z
	task automatic spi(input logic [2:0] c, input logic [23:0] a, input int n, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [47:0] f;
		f = {c, a, 5'h15, wd};
		rd = 16'h0000;
		#9.3 o_cs_n = 1'b0;
		for (int i = 0; i < 32 + 8 * n; i++) begin
			#1 o_sin = f[47 - i];
			#23 o_lclk = 1'b1;
			if (i > 31)
				rd = {rd[14:0], i_so_oe ? i_so : 1'bz};
			#24 o_lclk = 1'b0;
		end
		#24 o_cs_n = 1'b1;
		o_sin = ~o_sin;
	endtask
	// mdio frame at 200 ns; host lets go from turnaround on reads
	task automatic mdio(input logic [1:0] op, input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] wd,
		output logic [15:0] rd, output logic ta);
		logic [63:0] f;
		f = {32'hFFFFFFFF, 2'h1, op, ph, rg, 2'h2, wd};
		rd = 16'h0000;
		ta = 1'b1;
		#1.3;
		for (int i = 0; i < 64; i++) begin
			#1 o_md_oe = !(op == MDIO_OP_RD && i > 45);
			o_md_o = f[63 - i];
			#99 o_lclk = 1'b1;
			if (i == 47)
				ta = i_md;
			if (i > 47)
				rd = {rd[14:0], i_md};
			#100 o_lclk = 1'b0;
		end
		#1 o_md_oe = 1'b0;
	endtask
	// start (s = 1) or stop (s = 0): SDA is set up before SCL rises, then flipped while SCL is high
	task automatic i2c_edge(input logic s);
		#100 o_sda = s;
		#100 o_scl = 1'b1;
		#100 o_sda = !s;
		if (s)
			#100 o_scl = 1'b0;
	endtask
	// byte MSB first, then the ack slot; r and a return what stood on the wire
	task automatic i2c_byte(input logic [7:0] b, input logic k, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			#100 o_sda = b[i];
			#100 o_scl = 1'b1;
			#100 r[i] = i_sda;
			#100 o_scl = 1'b0;
		end
		#100 o_sda = k;
		#100 o_scl = 1'b1;
		#100 a = i_sda;
		#100 o_scl = 1'b0;
	endtask
endmodule
`default_nettype wire

/* dv/smhp_core_bench.sv */
// Purpose: self-checking bench for the host port
// Assumes: bench is the register space
// Notes: SPI, MDIO and I2C each run behind a reset of their own
`timescale 1ns/1ps
`default_nettype none
module smhp_core_bench;
	import smhp_pkg::*;
	logic i_clk, i_rst_n, lclk, cs_n, sin, so, so_oe, md_o, md_oe, hmd_o, hmd_oe, md_w, rwr, rrd;
	logic scl, hsda, sda_w, sda_o, sda_oe;
	logic [1:0] strap;
	logic [ADDR_W-1:0] raddr;
	logic [BYTE_W-1:0] wdat, rdat;
	logic [7:0] mem [0:65535];
	logic [15:0] rd;
	logic ta;
	int failures = 0;
	int checks = 0;
	int nwr = 0;
	int nrd = 0;
	// pulled-up wire; either side may pull low
	assign md_w = (hmd_oe ? hmd_o : 1'b1) & ~(md_oe & ~md_o);
	assign sda_w = hsda & ~(sda_oe & ~sda_o);
	assign rdat = mem[raddr];
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	smhp_core dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode_strap(strap), .i_lclk(lclk),
		.i_chip_select_low_n(cs_n), .i_serial_in_line(sin), .o_serial_out_line(so), .o_serial_out_line_oe(so_oe),
		.i_mdio_i(md_w), .o_mdio_o(md_o), .o_mdio_oe(md_oe), .i_i2c_scl(scl), .i_i2c_sda_i(sda_w),
		.o_i2c_sda_o(sda_o), .o_i2c_sda_oe(sda_oe), .o_reg_addr(raddr), .o_reg_wdata(wdat), .o_reg_wr(rwr),
		.o_reg_rd(rrd), .i_reg_rdata(rdat));
	smhp_host_model host_u (.o_lclk(lclk), .o_cs_n(cs_n), .o_sin(sin), .o_md_o(hmd_o), .o_md_oe(hmd_oe),
		.o_scl(scl), .o_sda(hsda), .i_so(so), .i_so_oe(so_oe), .i_md(md_w), .i_sda(sda_w));
	// register space; counts strobes to spot stray accesses
	always @(posedge i_clk) begin
		if (rwr) begin
			mem[raddr] <= wdat;
			nwr <= nwr + 1;
		end
		if (rrd)
			nrd <= nrd + 1;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// strap must be steady before release
	task automatic do_reset(input logic [1:0] m);
		i_rst_n <= 1'b0;
		strap <= m;
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (10) @(posedge i_clk);
	endtask
	task automatic wait_wr(input int n);
		for (int i = 0; i < 100 && nwr < n; i++)
			@(posedge i_clk);
		chk("writes", n[15:0], nwr[15:0]);
		if (nwr < n)
			conclude();
	endtask
	// refused frames: give late strobes time to show
	task automatic quiet(input int w, input int r);
		repeat (30) @(posedge i_clk);
		chk("stray wr", w[15:0], nwr[15:0]);
		chk("stray rd", r[15:0], nrd[15:0]);
	endtask
	task automatic t_spi_write();
		wait_wr(0);
		host_u.spi(SPI_CMD_WR, 24'hA53C7E, 2, 16'h964B, rd);
		wait_wr(2);
		chk("spi wr", 16'h964B, {mem[16'h3C7E], mem[16'h3C7F]});
		$display("end spi write");
	endtask
	task automatic t_spi_read();
		mem[16'h1230] = 8'hC3;
		mem[16'h1231] = 8'h5A;
		host_u.spi(SPI_CMD_RD, 24'hFF1230, 2, 16'hFFFF, rd);
		chk("spi rd", 16'hC35A, rd);
		$display("end spi read");
	endtask
	task automatic t_spi_bad();
		int w, r;
		repeat (20) @(posedge i_clk);
		w = nwr;
		r = nrd;
		host_u.spi(3'h7, 24'h003C7E, 1, 16'h0000, rd);
		chk("bad cmd out", 16'h00ZZ, rd);
		quiet(w, r);
		$display("end spi refused");
	endtask
	task automatic t_mdio_rw();
		// throwaway frame: the link side learns the mode on its first clocks
		host_u.mdio(2'h3, 5'h00, 5'h00, 16'h0000, rd, ta);
		host_u.mdio(MDIO_OP_WR, 5'h03, 5'h04, 16'hBEEF, rd, ta);
		wait_wr(4);
		chk("mdio wr", 16'hBEEF, {mem[16'h3108], mem[16'h3109]});
		mem[16'h5102] = 8'h12;
		mem[16'h5103] = 8'h34;
		host_u.mdio(MDIO_OP_RD, 5'h05, 5'h01, 16'h0000, rd, ta);
		chk("mdio rd", 16'h1234, rd);
		chk("mdio ta", 16'h0000, {15'h0000, ta});
		$display("end mdio access");
	endtask
	task automatic t_mdio_bad();
		int w, r;
		w = nwr;
		r = nrd;
		host_u.mdio(MDIO_OP_WR, 5'h06, 5'h00, 16'hA5A5, rd, ta);
		host_u.mdio(MDIO_OP_RD, 5'h00, 5'h00, 16'h0000, rd, ta);
		chk("phy 0 rd", 16'hFFFF, rd);
		quiet(w, r);
		$display("end mdio refused");
	endtask
	// burst write, random read of two bytes, then a foreign slave address
	task automatic t_i2c();
		logic [8:0] ak;
		logic [7:0] b0, b1, x;
		logic y, na;
		int w, r;
		host_u.i2c_edge(1'b1);
		host_u.i2c_byte(8'hBE, 1'b1, x, ak[0]);
		host_u.i2c_byte(8'h24, 1'b1, x, ak[1]);
		host_u.i2c_byte(8'h68, 1'b1, x, ak[2]);
		host_u.i2c_byte(8'hA1, 1'b1, x, ak[3]);
		host_u.i2c_byte(8'h7E, 1'b1, x, ak[4]);
		host_u.i2c_edge(1'b0);
		chk("i2c wr", 16'hA17E, {mem[16'h2468], mem[16'h2469]});
		host_u.i2c_edge(1'b1);
		host_u.i2c_byte(8'hBE, 1'b1, x, ak[5]);
		host_u.i2c_byte(8'h24, 1'b1, x, ak[6]);
		host_u.i2c_byte(8'h68, 1'b1, x, ak[7]);
		host_u.i2c_edge(1'b1);
		host_u.i2c_byte(8'hBF, 1'b1, x, ak[8]);
		host_u.i2c_byte(8'hFF, 1'b0, b0, y);
		host_u.i2c_byte(8'hFF, 1'b1, b1, y);
		host_u.i2c_edge(1'b0);
		chk("i2c rd", 16'hA17E, {b0, b1});
		chk("i2c ack", 16'h0000, {7'h00, ak});
		w = nwr;
		r = nrd;
		host_u.i2c_edge(1'b1);
		host_u.i2c_byte(8'hBC, 1'b1, x, na);
		host_u.i2c_edge(1'b0);
		chk("i2c nack", 16'h0001, {15'h0000, na});
		quiet(w, r);
		$display("end i2c access");
	endtask
	initial begin
		i_rst_n = 1'b0;
		strap = MODE_SPI;
		do_reset(MODE_SPI);
		t_spi_write();
		t_spi_read();
		t_spi_bad();
		do_reset(MODE_MDIO);
		t_mdio_rw();
		t_mdio_bad();
		do_reset(MODE_I2C);
		t_i2c();
		conclude();
	end
endmodule
`default_nettype wire
